// *** spi_pkg.sv ***
// Shared constants and types for the serial peripheral port.
package spi_pkg;

  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int RATE_W = 7;
  localparam int SYNC_W = 4;

  // Bit positions of the synchronised pin vector.
  localparam int PIN_SCLK = 3;
  localparam int PIN_SS = 2;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 0;

  localparam logic [CNT_W-1:0] BITS_PER_XFER = 4'h8;
  localparam logic [CNT_W-1:0] LAST_SAMPLE_CPHA1 = 4'h7;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  // Rate select codes and the terminal count of one half bit time.
  localparam logic [1:0] RATE_RATE_DIVIDE_BY_TWO = 2'h0;
  localparam logic [1:0] RATE_RATE_DIVIDE_BY_EIGHT = 2'h1;
  localparam logic [1:0] RATE_RATE_DIVIDE_BY_THIRTYTWO = 2'h2;
  localparam logic [1:0] RATE_RATE_DIVIDE_BY_ONETWENTYEIGHT = 2'h3;
  localparam logic [RATE_W-1:0] HALF_LIM_RATE_DIVIDE_BY_TWO = 7'h00;
  localparam logic [RATE_W-1:0] HALF_LIM_RATE_DIVIDE_BY_EIGHT = 7'h03;
  localparam logic [RATE_W-1:0] HALF_LIM_RATE_DIVIDE_BY_THIRTYTWO = 7'h0f;
  localparam logic [RATE_W-1:0] HALF_LIM_RATE_DIVIDE_BY_ONETWENTYEIGHT = 7'h3f;
  localparam logic [RATE_W-1:0] RATE_CNT_RST = 7'h00;
  localparam logic [RATE_W-1:0] RATE_CNT_ONE = 7'h01;

  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PEND = 3'b010,
    ST_ACTIVE = 3'b100
  } xfer_state_e;

endpackage

// *** spi_rate_gen.sv ***
// Free-running half-bit tick generator for the master serial clock.
module spi_rate_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic [1:0] rate_select_field,
  // Half-bit tick
  output logic tick
);

  logic [spi_pkg::RATE_W-1:0] cnt;
  logic [spi_pkg::RATE_W-1:0] next_cnt;
  logic [spi_pkg::RATE_W-1:0] lim;

  always_comb begin
    unique case (rate_select_field)
      spi_pkg::RATE_RATE_DIVIDE_BY_TWO: lim = spi_pkg::HALF_LIM_RATE_DIVIDE_BY_TWO;
      spi_pkg::RATE_RATE_DIVIDE_BY_EIGHT: lim = spi_pkg::HALF_LIM_RATE_DIVIDE_BY_EIGHT;
      spi_pkg::RATE_RATE_DIVIDE_BY_THIRTYTWO: lim = spi_pkg::HALF_LIM_RATE_DIVIDE_BY_THIRTYTWO;
      spi_pkg::RATE_RATE_DIVIDE_BY_ONETWENTYEIGHT: lim = spi_pkg::HALF_LIM_RATE_DIVIDE_BY_ONETWENTYEIGHT;
    endcase
  end

  // The divider is held cleared unless the port is an enabled master, to save power.
  assign tick = run && (cnt == lim);

  always_comb begin
    next_cnt = cnt + spi_pkg::RATE_CNT_ONE;
    if (!run || tick) begin
      next_cnt = spi_pkg::RATE_CNT_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= spi_pkg::RATE_CNT_RST;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

// *** spi_port.sv ***
// Serial peripheral port: master and slave shifter with transmit buffer and receive register.

// How it works
// - Master-select clear makes the port a slave clocked by the incoming serial clock.
// - A completed slave byte goes to the receive register and sets receive-full.
// - A slave follows any incoming clock up to half the bus rate, ignoring the rate field.
// - Without a new byte the slave shifts out what its shift register holds.
// - A byte written mid-transfer waits in the buffer until the transfer ends.
// - Slave start is select falling with phase 0, first clock edge with phase 1.
// - Polarity and phase bits pick one of four clock formats.
// - Master and slave use matching polarity and phase for each transfer.
// - A slave drives its output line only while its select is low.
// - With phase 0 the slave presents its top bit as select falls.
// - Once a slave transfer starts the shift register is not reloaded.
// - With phase 1 data moves on the first edge; select may stay low.
// - A master write starts a transfer; phase sets the clock's opening half.
// - The master clock divider runs only when enabled as master.
// - Master start follows the data write within one serial bit time.
// - A byte completing while the last is unread sets overflow and is dropped.
// - With fault detection on, select rising mid-transfer sets mode fault.
module spi_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control bits
  input wire logic port_enable_bit,
  input wire logic master_select_bit,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic [1:0] rate_select_field,
  input wire logic mode_fault_enable_bit,
  // Processor data side
  input wire logic tx_write,
  input wire logic [7:0] tx_data,
  input wire logic rx_read,
  input wire logic fault_clear,
  output logic [7:0] rx_data,
  output logic receive_full_flag,
  output logic transmit_empty_flag,
  output logic overflow_flag,
  output logic mode_fault_flag,
  // Serial pins
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_b_in
);

  logic [spi_pkg::SYNC_W-1:0] pin_raw;
  logic [spi_pkg::SYNC_W-1:0] sync1;
  logic [spi_pkg::SYNC_W-1:0] sync2;
  logic sclk_d;
  logic ss_d;
  logic sclk_s, ss_b_s, mosi_s, miso_s;
  logic mst, slv, tick, cpha;
  logic s_lead, s_trail, m_lead, m_trail, lead, trail;
  logic ss_fall, ss_rise, slave_start, master_fault, bit_in, done;
  logic [7:0] done_byte;

  spi_pkg::xfer_state_e state, next_state;
  logic [7:0] shift, next_shift;
  logic [7:0] tx_buf, next_tx_buf;
  logic tx_full, next_tx_full;
  logic [3:0] cnt, next_cnt;
  logic in_bit, next_in_bit;
  logic sclk_act, next_sclk_act;
  logic [7:0] next_rx_data;
  logic next_receive_full, next_overflow, next_mode_fault;

  assign pin_raw = {serial_clock_pin_in, ss_b_in, mosi_in, miso_in};

  // Every pin passes two flops before any logic looks at it.
  for (genvar i = 0; i < spi_pkg::SYNC_W; i++) begin : g_sync
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        sync1[i] <= spi_pkg::SYNC_RST[i];
        sync2[i] <= spi_pkg::SYNC_RST[i];
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
      end
    end
  end

  assign sclk_s = sync2[spi_pkg::PIN_SCLK];
  assign ss_b_s = sync2[spi_pkg::PIN_SS];
  assign mosi_s = sync2[spi_pkg::PIN_MOSI];
  assign miso_s = sync2[spi_pkg::PIN_MISO];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d <= 1'b0;
      ss_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      ss_d <= ss_b_s;
    end
  end

  assign mst = port_enable_bit && master_select_bit;
  assign slv = port_enable_bit && !master_select_bit;
  assign cpha = clock_phase_bit;

  spi_rate_gen u_rate (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(mst),
    .rate_select_field(rate_select_field),
    .tick(tick)
  );

  // Slave edges come straight from the sampled pin, so no rate setting is involved.
  assign s_lead = slv && !ss_b_s && ((sclk_s ^ clock_polarity_bit) && !(sclk_d ^ clock_polarity_bit));
  assign s_trail = slv && !ss_b_s && (!(sclk_s ^ clock_polarity_bit) && (sclk_d ^ clock_polarity_bit));
  assign m_lead = mst && tick && ((state == spi_pkg::ST_ACTIVE && !sclk_act) || (state == spi_pkg::ST_PEND && cpha));
  assign m_trail = mst && tick && state == spi_pkg::ST_ACTIVE && sclk_act;
  assign lead = s_lead || (m_lead && state == spi_pkg::ST_ACTIVE);
  assign trail = s_trail || m_trail;

  assign ss_fall = ss_d && !ss_b_s;
  assign ss_rise = !ss_d && ss_b_s;
  assign slave_start = slv && state == spi_pkg::ST_IDLE && (cpha ? s_lead : ss_fall);
  assign master_fault = mst && mode_fault_enable_bit && !ss_b_s;
  assign bit_in = mst ? miso_s : mosi_s;
  assign done = state == spi_pkg::ST_ACTIVE && trail &&
                (cpha ? (cnt == spi_pkg::LAST_SAMPLE_CPHA1) : (cnt == spi_pkg::BITS_PER_XFER));
  assign done_byte = {shift[6:0], cpha ? bit_in : in_bit};

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_tx_buf = tx_buf;
    next_tx_full = tx_full;
    next_cnt = cnt;
    next_in_bit = in_bit;
    next_sclk_act = sclk_act;
    unique case (state)
      spi_pkg::ST_IDLE: begin
        next_sclk_act = 1'b0;
        if (slave_start) begin
          next_state = spi_pkg::ST_ACTIVE;
          next_cnt = spi_pkg::CNT_RST;
        end else if (tx_full && (mst || slv)) begin
          // An idle port takes the buffered byte at once; otherwise the old content stays.
          next_shift = tx_buf;
          next_tx_full = 1'b0;
          if (mst) begin
            next_state = spi_pkg::ST_PEND;
          end
        end
      end
      spi_pkg::ST_PEND: begin
        if (!mst || master_fault) begin
          next_state = spi_pkg::ST_IDLE;
        end else if (tick) begin
          // The next half-bit tick opens the transfer, well inside one bit time.
          next_state = spi_pkg::ST_ACTIVE;
          next_cnt = spi_pkg::CNT_RST;
          next_sclk_act = cpha;
        end
      end
      spi_pkg::ST_ACTIVE: begin
        if (!port_enable_bit || (master_select_bit ? master_fault : ss_b_s)) begin
          next_state = spi_pkg::ST_IDLE;
          next_sclk_act = 1'b0;
        end else begin
          if (mst && tick) begin
            next_sclk_act = !sclk_act;
          end
          if (lead) begin
            if (!cpha) begin
              next_in_bit = bit_in;
              next_cnt = cnt + spi_pkg::CNT_ONE;
            end else if (cnt != spi_pkg::CNT_RST) begin
              next_shift = {shift[6:0], in_bit};
            end
          end
          if (trail) begin
            if (cpha) begin
              next_in_bit = bit_in;
              next_cnt = cnt + spi_pkg::CNT_ONE;
            end else begin
              next_shift = {shift[6:0], in_bit};
            end
          end
          if (done) begin
            next_state = spi_pkg::ST_IDLE;
            next_shift = done_byte;
            next_cnt = spi_pkg::CNT_RST;
          end
        end
      end
      default: begin
        next_state = spi_pkg::ST_IDLE;
      end
    endcase
    // A write during a transfer only fills the buffer; it never reaches the shifter here.
    if (tx_write) begin
      next_tx_buf = tx_data;
      next_tx_full = 1'b1;
    end
  end

  // Flags: a setting event wins over a clear in the same cycle.
  always_comb begin
    next_rx_data = rx_data;
    next_receive_full = receive_full_flag && !rx_read;
    next_overflow = overflow_flag && !rx_read;
    next_mode_fault = mode_fault_flag && !fault_clear;
    if (done) begin
      if (next_receive_full || next_overflow) begin
        next_overflow = 1'b1;
      end else begin
        next_rx_data = done_byte;
        next_receive_full = 1'b1;
      end
    end
    if (mode_fault_enable_bit && ((slv && state == spi_pkg::ST_ACTIVE && ss_rise) || master_fault)) begin
      next_mode_fault = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= spi_pkg::ST_IDLE;
      shift <= spi_pkg::BYTE_RST;
      tx_buf <= spi_pkg::BYTE_RST;
      tx_full <= 1'b0;
      cnt <= spi_pkg::CNT_RST;
      in_bit <= 1'b0;
      sclk_act <= 1'b0;
      rx_data <= spi_pkg::BYTE_RST;
      receive_full_flag <= 1'b0;
      overflow_flag <= 1'b0;
      mode_fault_flag <= 1'b0;
    end else begin
      state <= next_state;
      shift <= next_shift;
      tx_buf <= next_tx_buf;
      tx_full <= next_tx_full;
      cnt <= next_cnt;
      in_bit <= next_in_bit;
      sclk_act <= next_sclk_act;
      rx_data <= next_rx_data;
      receive_full_flag <= next_receive_full;
      overflow_flag <= next_overflow;
      mode_fault_flag <= next_mode_fault;
    end
  end

  assign transmit_empty_flag = !tx_full;
  assign serial_clock_pin_out = sclk_act ^ clock_polarity_bit;
  assign serial_clock_pin_oe = mst;
  assign mosi_out = shift[7];
  assign mosi_oe = mst;
  assign miso_out = shift[7];
  assign miso_oe = slv && !ss_b_s;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_miso_only_selected;
    miso_oe |-> !master_select_bit && !ss_b_s;
  endproperty
  a_miso_only_selected: assert property (p_miso_only_selected) else $error("slave drives data while unselected");

  property p_rx_capture;
    done && !receive_full_flag && !overflow_flag |=> receive_full_flag && rx_data == $past(done_byte);
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("completed byte not captured");

  property p_overflow_keeps;
    done && receive_full_flag && !rx_read |=> overflow_flag && $stable(rx_data);
  endproperty
  a_overflow_keeps: assert property (p_overflow_keeps) else $error("overflow not flagged or data replaced");

  property p_no_reload;
    state == spi_pkg::ST_ACTIVE && !lead && !trail && port_enable_bit |=> $stable(shift);
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("shifter changed without a clock edge");

  property p_buffer_waits;
    state == spi_pkg::ST_ACTIVE && tx_write |=> !transmit_empty_flag;
  endproperty
  a_buffer_waits: assert property (p_buffer_waits) else $error("write during transfer not held");

  property p_slave_start;
    slv && !cpha && state == spi_pkg::ST_IDLE && ss_fall |=> state == spi_pkg::ST_ACTIVE ##0 miso_out == $past(shift[7]);
  endproperty
  a_slave_start: assert property (p_slave_start) else $error("select fall did not start transfer");

  property p_mode_fault;
    mode_fault_enable_bit && slv && state == spi_pkg::ST_ACTIVE && ss_rise |=> mode_fault_flag && state == spi_pkg::ST_IDLE;
  endproperty
  a_mode_fault: assert property (p_mode_fault) else $error("select rise mid transfer not flagged");

  property p_start_latency;
    state == spi_pkg::ST_IDLE ##1 state == spi_pkg::ST_PEND |-> ##[1:64] state != spi_pkg::ST_PEND;
  endproperty
  a_start_latency: assert property (p_start_latency) else $error("master start exceeded one bit time");

  property p_clock_idle;
    state != spi_pkg::ST_ACTIVE |-> serial_clock_pin_out == clock_polarity_bit;
  endproperty
  a_clock_idle: assert property (p_clock_idle) else $error("master clock left idle outside transfer");

  property p_divider_gated;
    !mst |-> !tick;
  endproperty
  a_divider_gated: assert property (p_divider_gated) else $error("rate divider ticking while not master");

endmodule

// *** spi_remote_master.sv ***
// Behavioural remote master that clocks the port when it works as a slave.
module spi_remote_master (
  // Serial pins toward the port
  output logic sclk,
  output logic mosi,
  output logic ss_b,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ss_b = 1'b1;
  end

  // Parks the clock at its idle level while the slave is still disabled.
  task automatic idle(input logic pol);
    #1;
    sclk = pol;
  endtask

  // Shifts n bits; fewer than eight lets select rise in mid-byte.
  task automatic xfer(input logic [7:0] d, input logic pol, input logic pha, input logic keep, input int n,
                      output logic [7:0] q);
    int i;
    q = 8'h00;
    // Pin changes are kept off the bus clock edges so that the synchronisers never race them.
    #1;
    ss_b = 1'b0;
    mosi = d[7];
    #40;
    for (i = 0; i < n; i++) begin
      sclk = ~pol;
      if (pha) begin
        mosi = d[7-i];
      end else begin
        q = {q[6:0], miso};
      end
      #40;
      sclk = pol;
      if (pha) begin
        q = {q[6:0], miso};
      end else if (i < 7) begin
        mosi = d[6-i];
      end
      #40;
    end
    if (!keep) begin
      ss_b = 1'b1;
    end
    mosi = ~mosi;
    #40;
  endtask
endmodule

// *** spi_port_tb_top.sv ***
// Self-checking bench for the serial peripheral port in slave and master modes.
module spi_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic en = 1'b0, ms = 1'b0, pol = 1'b0, pha = 1'b0, fen = 1'b0;
  logic [1:0] rate = 2'h0;
  logic tx_write = 1'b0, rx_read = 1'b0, fault_clear = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rx_data;
  logic rf, te, ov, mf, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic r_sclk, r_mosi, r_ss_b, miso_rel = 1'b0;
  wire logic miso_w = miso_oe ? miso_out : miso_rel;
  // At the fastest rate half a bit is shorter than the two-flop input delay, so the master hears a steady high line.
  wire logic miso_loop = (rate == 2'h0) ? 1'b1 : mosi_out;
  int miscompares = 0;
  int checks = 0;

  always #2 ref_clk = ~ref_clk;

  // A released output line shows the inverse of its last driven value.
  always @(posedge ref_clk) begin
    if (miso_oe) begin
      miso_rel <= ~miso_out;
    end
  end

  spi_port DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .port_enable_bit(en), .master_select_bit(ms),
    .clock_polarity_bit(pol), .clock_phase_bit(pha), .rate_select_field(rate),
    .mode_fault_enable_bit(fen), .tx_write(tx_write), .tx_data(tx_data), .rx_read(rx_read),
    .fault_clear(fault_clear), .rx_data(rx_data), .receive_full_flag(rf), .transmit_empty_flag(te),
    .overflow_flag(ov), .mode_fault_flag(mf), .serial_clock_pin_in(r_sclk),
    .serial_clock_pin_out(sclk_out), .serial_clock_pin_oe(sclk_oe), .mosi_in(r_mosi),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_loop), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_b_in(r_ss_b)
  );

  spi_remote_master pm (.sclk(r_sclk), .mosi(r_mosi), .ss_b(r_ss_b), .miso(miso_w));

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk);
    tx_write <= 1'b1;
    tx_data <= d;
    @(posedge ref_clk);
    tx_write <= 1'b0;
  endtask

  task automatic rd();
    @(posedge ref_clk);
    rx_read <= 1'b1;
    @(posedge ref_clk);
    rx_read <= 1'b0;
  endtask

  // Reconfigures with the port disabled and the remote clock already idle.
  task automatic cfg(input logic m, input logic p, input logic h, input logic [1:0] r, input logic f);
    @(posedge ref_clk);
    en <= 1'b0;
    @(posedge ref_clk);
    ms <= m;
    pol <= p;
    pha <= h;
    rate <= r;
    fen <= f;
    pm.idle(p);
    cyc(4);
    en <= 1'b1;
    cyc(4);
  endtask

  task automatic slave_basic();
    logic [7:0] got;
    cfg(1'b0, 1'b0, 1'b0, 2'h3, 1'b0);
    chk("miso_oe_idle", miso_oe, 1'b0);
    chk("sclk_oe_slave", sclk_oe, 1'b0);
    wr(8'ha5);
    cyc(4);
    pm.xfer(8'h3c, 1'b0, 1'b0, 1'b0, 8, got);
    cyc(8);
    chk("slave_tx", got, 8'ha5);
    chk("slave_rx", rx_data, 8'h3c);
    chk("slave_rf", rf, 1'b1);
    chk("miso_oe_after", miso_oe, 1'b0);
    rd();
    cyc(2);
    chk("rf_cleared", rf, 1'b0);
  endtask

  task automatic slave_hold();
    logic [7:0] got;
    cfg(1'b0, 1'b1, 1'b1, 2'h0, 1'b0);
    fork
      pm.xfer(8'hc3, 1'b1, 1'b1, 1'b1, 8, got);
      begin
        cyc(40);
        wr(8'h96);
        cyc(2);
        chk("te_mid_xfer", te, 1'b0);
      end
    join
    cyc(8);
    chk("no_reload_tx", got, 8'h3c);
    chk("te_after_load", te, 1'b1);
    pm.xfer(8'h5a, 1'b1, 1'b1, 1'b0, 8, got);
    cyc(8);
    chk("queued_tx", got, 8'h96);
    chk("ovf_set", ov, 1'b1);
    chk("old_byte_kept", rx_data, 8'hc3);
    rd();
    cyc(2);
    chk("ovf_cleared", ov, 1'b0);
  endtask

  task automatic slave_fault();
    logic [7:0] got;
    cfg(1'b0, 1'b0, 1'b0, 2'h1, 1'b1);
    pm.xfer(8'hf0, 1'b0, 1'b0, 1'b0, 3, got);
    cyc(6);
    chk("mode_fault", mf, 1'b1);
    chk("no_rx_abort", rf, 1'b0);
    @(posedge ref_clk);
    fault_clear <= 1'b1;
    @(posedge ref_clk);
    fault_clear <= 1'b0;
    cyc(2);
    chk("fault_cleared", mf, 1'b0);
  endtask

  // Rate, phase and polarity all follow r, so four runs cover every format.
  task automatic master_run(input int r);
    logic p, h, last;
    int lat, edges, k, bit_c;
    logic [7:0] d;
    p = r[1];
    h = r[0];
    bit_c = 2 << (2 * r);
    d = 8'h5a ^ r[7:0];
    cfg(1'b1, p, h, r[1:0], 1'b0);
    chk("sclk_idle", sclk_out, p);
    chk("sclk_oe_master", sclk_oe, 1'b1);
    chk("mosi_oe_master", mosi_oe, 1'b1);
    wr(d);
    lat = 0;
    while (sclk_out === p && lat < 2000) begin
      @(posedge ref_clk);
      lat++;
    end
    chk("start_latency", lat <= (h ? bit_c + 2 : bit_c + bit_c / 2 + 2), 1'b1);
    chk("phase0_quiet", h || lat >= bit_c / 2 - 1, 1'b1);
    last = sclk_out;
    edges = 1;
    k = 0;
    while (rf !== 1'b1 && k < 4000) begin
      @(posedge ref_clk);
      if (sclk_out !== last) begin
        edges++;
      end
      last = sclk_out;
      k++;
    end
    chk("rx_in_time", k < 4000, 1'b1);
    chk("clock_edges", edges[7:0], 8'h10);
    chk("master_rx", rx_data, (r == 0) ? 8'hff : d);
    chk("sclk_back_idle", sclk_out, p);
    rd();
  endtask

  initial begin
    #200000;
    miscompares++;
    test_done();
  end

  initial begin
    cyc(5);
    rst_b <= 1'b1;
    cyc(3);
    chk("te_reset", te, 1'b1);
    slave_basic();
    slave_hold();
    slave_fault();
    for (int r = 0; r < 4; r++) begin
      master_run(r);
    end
    test_done();
  end
endmodule
